// ---- rtl/scd_pkg.sv ----
package scd_pkg;
  localparam int SCD_ROW_W = 12;
  localparam int SCD_BANKS = 4;
  localparam int SCD_BANK_W = 2;
  localparam int SCD_FLAG_BIT = 10;
  localparam int SCD_COL_TOP_X4 = 9;
  localparam int SCD_COL_TOP_X8 = 8;
  localparam int SCD_READ_MASK_LAT = 2;
  localparam int SCD_CLK_MHZ = 250;

  typedef enum logic [3:0] {
    SCD_CMD_NONE,
    SCD_CMD_ROW_OPEN,
    SCD_CMD_READ,
    SCD_CMD_WRITE,
    SCD_CMD_CLOSE,
    SCD_CMD_CLOSE_ALL,
    SCD_CMD_MODE_SET,
    SCD_CMD_IDLE,
    SCD_CMD_DESELECT,
    SCD_CMD_AUTO_REFRESH,
    SCD_CMD_SELF_REFRESH_ENTRY,
    SCD_CMD_SELF_REFRESH_EXIT,
    SCD_CMD_POWERDOWN_ENTRY,
    SCD_CMD_POWERDOWN_EXIT,
    SCD_CMD_SUSPEND
  } scd_cmd_e;

  typedef enum logic [1:0] {
    SCD_ST_NORMAL,
    SCD_ST_SELF_REFRESH,
    SCD_ST_POWERDOWN,
    SCD_ST_SUSPEND
  } scd_state_e;

  typedef struct packed {
    logic chipSelectN;
    logic rowStrobeN;
    logic colStrobeN;
    logic writeSelectN;
    logic dataMask;
    logic clockGate;
    logic [SCD_BANK_W-1:0] bankSelect;
    logic [SCD_ROW_W-1:0] addressInputs;
  } scd_pins_s;

  typedef struct packed {
    logic [SCD_BANK_W-1:0] bank;
    logic [SCD_ROW_W-1:0] colAddr;
    logic autoClose;
  } scd_access_s;
endpackage

// ---- rtl/scd_delay_line.sv ----
`timescale 1ns/1ps
module scd_delay_line #(
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic din,
  output logic dout
);
  logic [DEPTH-1:0] stage;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage <= '0;
    end else begin
      stage <= {stage[DEPTH-2:0], din};
    end
  end

  assign dout = stage[DEPTH-1];
endmodule // scd_delay_line

// ---- rtl/scd_command_decoder.sv ----
`timescale 1ns/1ps
// How it works
// - commands decoded only from pin levels sampled at rising clock edge
// - row-open to idle bank latches all twelve address bits as row
// - column uses address bits to 9 (x4) or 8 (x8)
// - high flag on read/write requests auto-close of selected bank
// - close with flag high closes all banks, else only selected bank
// - bank select picks bank for row-open, read, write, single close
// - read: select low, row strobe high, column strobe low, write select high
// - write: select low, row strobe high, column strobe low, write select low
// - mode set with all banks idle stores address and bank select
// - deselect and idle command are legal anywhere and do nothing
// - refresh code: auto refresh if gate high, self refresh if low
// - self refresh left on gate rising with deselect or idle code
// - power down entered on gate falling with deselect or idle code
// - power down left on gate rising with deselect or idle code
// - read mask disables output drive two cycles after sampling
// - write mask blocks data in same cycle
// - one mask governs all data lines
// - chip select high ignores new commands, bursts keep running
// - commands need gate high previous cycle; gate taken both cycles
// - power-down entry during burst enters clock suspend instead
// - low gate stops internal clock one edge later, whatever the command or state
module scd_command_decoder
  import scd_pkg::*;
#(
  parameter int DATA_W = 4,
  parameter int BURST_LEN = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // command pins
  input wire scd_pins_s pins,
  // write data from pins, and read data from array
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic [DATA_W-1:0] arrayReadData,
  // decoded results
  output scd_cmd_e command,
  output scd_state_e devState,
  output logic [SCD_BANKS-1:0] bankOpen,
  output logic [SCD_BANKS*SCD_ROW_W-1:0] rowAddr,
  output scd_access_s access,
  output logic accessValid,
  output logic [SCD_ROW_W+SCD_BANK_W-1:0] modeParams,
  output logic burstActive,
  output logic burstIsWrite,
  output logic internalClockOn,
  // data path
  output logic writeStrobe,
  output logic [DATA_W-1:0] writeData,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOutEn
);
  localparam int BCNT_W = $clog2(BURST_LEN + 1);
  localparam logic [BCNT_W-1:0] BURST_LOAD = BCNT_W'(BURST_LEN);

  logic gatePrev;
  logic [BCNT_W-1:0] burstCount;
  logic [SCD_BANK_W-1:0] burstBank;
  logic burstAutoClose;
  logic maskDelayed;
  logic csLow, rasLow, casLow, weLow, gateNow, flag;
  logic idleCode, allIdle, selOpen;
  scd_cmd_e next_command;
  logic [SCD_BANK_W-1:0] sel;
  logic [SCD_ROW_W-1:0] colMask;

  assign csLow = !pins.chipSelectN;
  assign rasLow = !pins.rowStrobeN;
  assign casLow = !pins.colStrobeN;
  assign weLow = !pins.writeSelectN;
  assign gateNow = pins.clockGate;
  assign flag = pins.addressInputs[SCD_FLAG_BIT];
  assign sel = pins.bankSelect;
  assign allIdle = (bankOpen == '0);
  assign selOpen = bankOpen[sel];
  // deselect, or idle command with strobes high regardless of write select
  assign idleCode = !csLow || (!rasLow && !casLow);
  // x8 part drops column bit 9
  assign colMask = (DATA_W == 8) ? SCD_ROW_W'((1 << (SCD_COL_TOP_X8 + 1)) - 1)
                                 : SCD_ROW_W'((1 << (SCD_COL_TOP_X4 + 1)) - 1);

  ////////////////////////////////////////////////////////////////
  // command decode from sampled levels
  always_comb begin
    next_command = SCD_CMD_NONE;
    case (devState)
      SCD_ST_SELF_REFRESH: begin
        if (!gatePrev && gateNow && idleCode) begin
          next_command = SCD_CMD_SELF_REFRESH_EXIT;
        end
      end
      SCD_ST_POWERDOWN: begin
        if (!gatePrev && gateNow && idleCode) begin
          next_command = SCD_CMD_POWERDOWN_EXIT;
        end
      end
      SCD_ST_SUSPEND: begin
        if (gateNow) begin
          next_command = SCD_CMD_IDLE;
        end else begin
          next_command = SCD_CMD_SUSPEND;
        end
      end
      default: begin
        if (!gatePrev) begin
          next_command = SCD_CMD_NONE;
        end else if (!gateNow && idleCode) begin
          // burst in flight turns power-down entry into suspend
          next_command = burstActive ? SCD_CMD_SUSPEND
                                     : SCD_CMD_POWERDOWN_ENTRY;
        end else if (!csLow) begin
          next_command = SCD_CMD_DESELECT;
        end else begin
          case ({rasLow, casLow, weLow})
            3'b000: next_command = SCD_CMD_IDLE;
            3'b100: next_command = selOpen ? SCD_CMD_NONE : SCD_CMD_ROW_OPEN;
            3'b010: next_command = selOpen ? SCD_CMD_READ : SCD_CMD_NONE;
            3'b011: next_command = selOpen ? SCD_CMD_WRITE : SCD_CMD_NONE;
            3'b101: next_command = flag ? SCD_CMD_CLOSE_ALL : SCD_CMD_CLOSE;
            3'b111: next_command = allIdle ? SCD_CMD_MODE_SET : SCD_CMD_NONE;
            3'b110: begin
              if (!allIdle) begin
                next_command = SCD_CMD_NONE;
              end else if (gateNow) begin
                next_command = SCD_CMD_AUTO_REFRESH;
              end else begin
                next_command = SCD_CMD_SELF_REFRESH_ENTRY;
              end
            end
            default: next_command = SCD_CMD_NONE;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      command <= SCD_CMD_NONE;
      gatePrev <= 1'b1;
    end else begin
      command <= next_command;
      gatePrev <= gateNow;
    end
  end

  ////////////////////////////////////////////////////////////////
  // low-power state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      devState <= SCD_ST_NORMAL;
      internalClockOn <= 1'b1;
    end else begin
      case (next_command)
        SCD_CMD_SELF_REFRESH_ENTRY: devState <= SCD_ST_SELF_REFRESH;
        SCD_CMD_POWERDOWN_ENTRY: devState <= SCD_ST_POWERDOWN;
        SCD_CMD_SUSPEND: devState <= SCD_ST_SUSPEND;
        SCD_CMD_SELF_REFRESH_EXIT, SCD_CMD_POWERDOWN_EXIT, SCD_CMD_IDLE: begin
          if (devState != SCD_ST_NORMAL) begin
            devState <= SCD_ST_NORMAL;
          end
        end
        default: devState <= devState;
      endcase
      internalClockOn <= gateNow;
    end
  end

  ////////////////////////////////////////////////////////////////
  // bank rows, mode parameters
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bankOpen <= '0;
      rowAddr <= '0;
      modeParams <= '0;
    end else begin
      case (next_command)
        SCD_CMD_ROW_OPEN: begin
          bankOpen[sel] <= 1'b1;
          rowAddr[sel*SCD_ROW_W +: SCD_ROW_W] <= pins.addressInputs;
        end
        SCD_CMD_CLOSE: bankOpen[sel] <= 1'b0;
        SCD_CMD_CLOSE_ALL: bankOpen <= '0;
        SCD_CMD_MODE_SET: modeParams <= {pins.bankSelect, pins.addressInputs};
        default: begin
          // auto-close at burst end, running even under deselect
          if (burstActive && burstCount == BCNT_W'(1) && burstAutoClose
              && devState != SCD_ST_SUSPEND) begin
            bankOpen[burstBank] <= 1'b0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // column access and burst tracking
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      access <= '0;
      accessValid <= 1'b0;
      burstActive <= 1'b0;
      burstIsWrite <= 1'b0;
      burstCount <= '0;
      burstBank <= '0;
      burstAutoClose <= 1'b0;
    end else begin
      accessValid <= 1'b0;
      if (next_command == SCD_CMD_READ || next_command == SCD_CMD_WRITE) begin
        accessValid <= 1'b1;
        access.bank <= sel;
        access.colAddr <= pins.addressInputs & colMask;
        access.autoClose <= flag;
        burstActive <= 1'b1;
        burstIsWrite <= (next_command == SCD_CMD_WRITE);
        burstCount <= BURST_LOAD;
        burstBank <= sel;
        burstAutoClose <= flag;
      end else if (burstActive && devState != SCD_ST_SUSPEND) begin
        // a new burst interrupts; otherwise count down regardless of chip select
        burstCount <= burstCount - BCNT_W'(1);
        if (burstCount == BCNT_W'(1)) begin
          burstActive <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // data mask: zero latency on writes, two cycles on reads
  scd_delay_line #(
    .DEPTH(SCD_READ_MASK_LAT)
  ) uMaskDelay (
    .clk(clk),
    .rstn(rstn),
    .din(pins.dataMask),
    .dout(maskDelayed)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      writeStrobe <= 1'b0;
      writeData <= '0;
      dataOut <= '0;
      dataOutEn <= 1'b0;
    end else begin
      // single mask gates every data line together
      // first beat rides on the command edge, before burstIsWrite is updated;
      // last count is one past the burst length, and a frozen clock writes nothing
      writeStrobe <= (next_command == SCD_CMD_WRITE
                      || (burstActive && burstIsWrite && burstCount != BCNT_W'(1)
                          && next_command != SCD_CMD_READ
                          && next_command != SCD_CMD_SUSPEND
                          && devState != SCD_ST_SUSPEND))
                     && !pins.dataMask;
      writeData <= dataIn;
      dataOut <= arrayReadData;
      dataOutEn <= burstActive && !burstIsWrite && !maskDelayed;
    end
  end
endmodule // scd_command_decoder

// ---- test/scd_command_decoder_chk.sv ----
`timescale 1ns/1ps
module scd_command_decoder_chk
  import scd_pkg::*;
#(
  parameter int DATA_W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // watched ports
  input wire scd_pins_s pins,
  input wire logic [DATA_W-1:0] dataIn,
  input wire scd_cmd_e command,
  input wire scd_state_e devState,
  input wire logic [SCD_BANKS-1:0] bankOpen,
  input wire logic [SCD_BANKS*SCD_ROW_W-1:0] rowAddr,
  input wire scd_access_s access,
  input wire logic accessValid,
  input wire logic [SCD_ROW_W+SCD_BANK_W-1:0] modeParams,
  input wire logic burstActive,
  input wire logic burstIsWrite,
  input wire logic writeStrobe,
  input wire logic [DATA_W-1:0] writeData,
  input wire logic dataOutEn,
  input wire logic internalClockOn,
  input wire logic [DATA_W-1:0] dataOut,
  input wire logic [DATA_W-1:0] arrayReadData
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  localparam logic [11:0] CM = (DATA_W == 4) ? 12'h3FF : 12'h1FF;
  logic gp;
  wire [3:0] cd = {pins.chipSelectN, pins.rowStrobeN, pins.colStrobeN, pins.writeSelectN};
  wire [1:0] bs = pins.bankSelect;
  wire [11:0] ad = pins.addressInputs;
  wire fl = ad[10];
  wire c0 = cd[0];
  wire ok = gp && devState == SCD_ST_NORMAL;
  wire idl = cd[3] || cd[2:1] == 2'b11;
  // gate one edge back; starts high so the first edge may carry a command
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gp <= 1'b1;
    end else begin
      gp <= pins.clockGate;
    end
  end
  ////////////////////////////////////////////////////////////
  property p_row;
    cd == 4'h3 && ok && !bankOpen[bs] |=> command == SCD_CMD_ROW_OPEN && bankOpen[$past(bs)]
      && rowAddr[$past(bs)*SCD_ROW_W +: SCD_ROW_W] == $past(ad);
  endproperty
  a_row: assert property (p_row) else $error("row open not latched");
  property p_rd;
    cd[3:1] == 3'b010 && ok && bankOpen[bs] |=> accessValid && access.bank == $past(bs)
      && access.autoClose == $past(fl) && access.colAddr == ($past(ad) & CM)
      && command == ($past(c0) ? SCD_CMD_READ : SCD_CMD_WRITE) && burstIsWrite != $past(c0);
  endproperty
  a_rd: assert property (p_rd) else $error("column access wrong");
  property p_cls;
    cd == 4'h2 && ok |=> $past(fl) ? bankOpen == 4'h0 : !bankOpen[$past(bs)];
  endproperty
  a_cls: assert property (p_cls) else $error("close left bank open");
  property p_mode;
    cd == 4'h0 && ok && bankOpen == 4'h0 |=> command == SCD_CMD_MODE_SET
      && modeParams == {$past(bs), $past(ad)};
  endproperty
  a_mode: assert property (p_mode) else $error("mode values not taken");
  property p_desel;
    cd[3] && pins.clockGate && ok |=> command == SCD_CMD_DESELECT;
  endproperty
  a_desel: assert property (p_desel) else $error("deselect not reported");
  property p_ref;
    cd == 4'h1 && ok && bankOpen == 4'h0 |=>
      $past(pins.clockGate) ? command == SCD_CMD_AUTO_REFRESH : devState == SCD_ST_SELF_REFRESH;
  endproperty
  a_ref: assert property (p_ref) else $error("refresh decode wrong");
  property p_pdn;
    ok && !pins.clockGate && idl |=>
      devState == ($past(burstActive) ? SCD_ST_SUSPEND : SCD_ST_POWERDOWN);
  endproperty
  a_pdn: assert property (p_pdn) else $error("gate fall state wrong");
  property p_exit;
    devState inside {SCD_ST_SELF_REFRESH, SCD_ST_POWERDOWN} && !gp && pins.clockGate && idl
      |=> devState == SCD_ST_NORMAL;
  endproperty
  a_exit: assert property (p_exit) else $error("low power exit missed");
  property p_wm;
    writeStrobe |-> !$past(pins.dataMask) && writeData == $past(dataIn);
  endproperty
  a_wm: assert property (p_wm) else $error("masked beat written");
  property p_rm;
    pins.dataMask [*4] |-> !dataOutEn;
  endproperty
  a_rm: assert property (p_rm) else $error("output drive under mask");
  property p_wbeat;
    cd == 4'h4 && ok && bankOpen[bs] && !pins.dataMask |=> writeStrobe;
  endproperty
  a_wbeat: assert property (p_wbeat) else $error("first write beat lost");
  property p_clk;
    internalClockOn == gp;
  endproperty
  a_clk: assert property (p_clk) else $error("internal clock not following gate");
  property p_dout;
    1'b1 |=> dataOut == $past(arrayReadData);
  endproperty
  a_dout: assert property (p_dout) else $error("read data not passed on");
endmodule // scd_command_decoder_chk

// ---- test/scd_ctrl_model.sv ----
`timescale 1ns/1ps
module scd_ctrl_model
  import scd_pkg::*;
(
  // bench clock
  input wire logic clk,
  // pins toward the device
  output scd_pins_s pins,
  output logic [3:0] dataIn
);
  initial begin
    pins = {4'hF, 1'b0, 1'b1, 2'h0, 12'h000};
    dataIn = 4'h0;
  end
  // levels move only at the falling edge, so each rising edge sees one command
  task automatic put(input logic [3:0] cd, input logic g, input logic [1:0] b,
                     input logic [11:0] a, input logic dm, input logic [3:0] d);
    @(negedge clk);
    pins <= {cd, dm, g, b, a};
    dataIn <= dm ? ~dataIn : d; // masked beats carry a changing pattern
  endtask
endmodule // scd_ctrl_model

// ---- test/scd_command_decoder_tb_top.sv ----
`timescale 1ns/1ps
module scd_command_decoder_tb_top
  import scd_pkg::*;
;
  typedef struct {int c; bit k; logic [3:0] v;} scd_exp_s;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] rdData = 4'h5;
  logic [15:0] lf = 16'h28DB;
  int cyc = 0;
  int miscompares = 0;
  int num_checks = 0;
  scd_exp_s q[$];
  scd_pins_s pins;
  logic [3:0] dataIn;
  scd_cmd_e command;
  scd_state_e devState;
  logic [3:0] bankOpen;
  always #2 clk = ~clk;
  always @(negedge clk) rdData <= ~rdData;
  scd_ctrl_model scd_ctrl_model_i (.clk(clk), .pins(pins), .dataIn(dataIn));
  scd_command_decoder #(.DATA_W(4), .BURST_LEN(4)) scd_command_decoder_i (.clk(clk),
    .rstn(rstn), .pins(pins), .dataIn(dataIn), .arrayReadData(rdData), .command(command),
    .devState(devState), .bankOpen(bankOpen), .rowAddr(), .access(), .accessValid(),
    .modeParams(), .burstActive(), .burstIsWrite(), .internalClockOn(), .writeStrobe(),
    .writeData(), .dataOut(), .dataOutEn());
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk_cmd(input scd_cmd_e e);
    num_checks++;
    if (command !== e) begin
      miscompares++;
      $display("wrong value at %0t: command %0d, expected %0d", $time, command, e);
    end
  endtask
  task automatic chk_bank(input logic [3:0] e);
    num_checks++;
    if (bankOpen !== e) begin
      miscompares++;
      $display("wrong value at %0t: open banks %h, expected %h", $time, bankOpen, e);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // k low: result not defined in that cycle, nothing noted
  task automatic go(input logic [3:0] cd, input logic g, input logic [1:0] b,
                    input logic [11:0] a, input logic dm, input scd_cmd_e e, input bit k);
    lf = nx(lf);
    scd_ctrl_model_i.put(cd, g, b, a, dm, lf[3:0]);
    if (k) q.push_back('{cyc + 1, 1'b0, e});
  endtask
  task automatic expb(input logic [3:0] v);
    q.push_back('{cyc + 1, 1'b1, v});
  endtask
  always @(posedge clk) begin
    #1;
    cyc++;
    while (q.size() > 0 && q[0].c <= cyc) begin
      if (q[0].k) chk_bank(q[0].v);
      else chk_cmd(scd_cmd_e'(q[0].v));
      void'(q.pop_front());
    end
  end
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    for (int b = 0; b < 4; b++) begin
      go(4'h3, 1'b1, b[1:0], lf[15:4], 1'b0, SCD_CMD_ROW_OPEN, 1'b1);
    end
    expb(4'hF);
    go(4'h3, 1'b1, 2'h0, 12'h000, 1'b0, SCD_CMD_NONE, 1'b1);
    go(4'h5, 1'b1, 2'h0, 12'hBFF, 1'b0, SCD_CMD_READ, 1'b1);
    go(4'h5, 1'b1, 2'h1, 12'h400, 1'b0, SCD_CMD_READ, 1'b1);
    for (int i = 0; i < 6; i++) begin
      go(4'h7, 1'b1, 2'h0, 12'h000, i < 4, SCD_CMD_IDLE, 1'b1);
    end
    expb(4'hD);
    go(4'h5, 1'b1, 2'h1, 12'h000, 1'b0, SCD_CMD_NONE, 1'b1);
    go(4'h4, 1'b1, 2'h2, 12'h523, 1'b0, SCD_CMD_WRITE, 1'b1);
    for (int i = 0; i < 4; i++) begin
      go(4'h7, 1'b1, 2'h0, 12'h000, i[0], SCD_CMD_IDLE, 1'b1);
    end
    go(4'h2, 1'b1, 2'h3, 12'h000, 1'b0, SCD_CMD_CLOSE, 1'b1);
    expb(4'h1);
    go(4'h0, 1'b1, 2'h2, 12'h055, 1'b0, SCD_CMD_NONE, 1'b1);
    go(4'h2, 1'b1, 2'h1, 12'h400, 1'b0, SCD_CMD_CLOSE_ALL, 1'b1);
    expb(4'h0);
    go(4'h0, 1'b1, 2'h2, lf[11:0], 1'b0, SCD_CMD_MODE_SET, 1'b1);
    go(4'hF, 1'b1, 2'h3, 12'hFFF, 1'b0, SCD_CMD_DESELECT, 1'b1);
    go(4'h1, 1'b1, 2'h0, 12'h000, 1'b0, SCD_CMD_AUTO_REFRESH, 1'b1);
    go(4'h1, 1'b0, 2'h0, 12'h000, 1'b0, SCD_CMD_SELF_REFRESH_ENTRY, 1'b1);
    repeat (3) go(4'hF, 1'b0, 2'h0, 12'h000, 1'b0, SCD_CMD_NONE, 1'b1);
    go(4'h6, 1'b1, 2'h0, 12'h000, 1'b0, SCD_CMD_SELF_REFRESH_EXIT, 1'b1);
    go(4'h7, 1'b1, 2'h0, 12'h000, 1'b0, SCD_CMD_IDLE, 1'b1);
    go(4'hF, 1'b0, 2'h0, 12'h000, 1'b0, SCD_CMD_POWERDOWN_ENTRY, 1'b1);
    repeat (2) go(4'hF, 1'b0, 2'h0, 12'h000, 1'b0, SCD_CMD_NONE, 1'b1);
    go(4'hF, 1'b1, 2'h0, 12'h000, 1'b0, SCD_CMD_POWERDOWN_EXIT, 1'b1);
    go(4'h3, 1'b1, 2'h0, 12'h0A5, 1'b0, SCD_CMD_ROW_OPEN, 1'b1);
    go(4'h5, 1'b1, 2'h0, 12'h000, 1'b0, SCD_CMD_READ, 1'b1);
    repeat (3) go(4'h7, 1'b0, 2'h0, 12'h000, 1'b0, SCD_CMD_SUSPEND, 1'b1);
    repeat (6) go(4'h7, 1'b1, 2'h0, 12'h000, 1'b0, SCD_CMD_IDLE, 1'b1);
    go(4'h3, 1'b0, 2'h1, 12'h000, 1'b0, SCD_CMD_ROW_OPEN, 1'b1);
    go(4'h3, 1'b1, 2'h2, 12'h000, 1'b0, SCD_CMD_NONE, 1'b1);
    for (int i = 0; i < 20 && q.size() > 0; i++) @(posedge clk);
    if (q.size() > 0) miscompares++;
    end_sim();
  end
endmodule // scd_command_decoder_tb_top
bind scd_command_decoder scd_command_decoder_chk #(.DATA_W(DATA_W)) scd_command_decoder_chk_i (
  .clk(clk), .rstn(rstn), .pins(pins), .dataIn(dataIn), .command(command),
  .devState(devState), .bankOpen(bankOpen), .rowAddr(rowAddr), .access(access),
  .accessValid(accessValid), .modeParams(modeParams), .burstActive(burstActive),
  .burstIsWrite(burstIsWrite), .writeStrobe(writeStrobe), .writeData(writeData),
  .dataOutEn(dataOutEn), .internalClockOn(internalClockOn), .dataOut(dataOut),
  .arrayReadData(arrayReadData));
